// ### test/mwfd_core_props.sv
// bound checker for the multiword fetch/decode front end
`include "mwfd_cfg.svh"
module mwfd_core_props
#(
    parameter int PC_W = 21
)
(
    // watched ports
    input wire logic              i_sys_clk,
    input wire logic              i_sys_rst,
    input wire logic [PC_W-1:0]   o_fetch_addr,
    input wire logic              o_fetch_req,
    input wire logic [15:0]       i_fetch_word,
    input wire logic              i_fetch_valid,
    input wire logic              i_skip,
    input wire logic              o_dec_valid,
    input mwfd_pkg::mwfd_op_t     o_dec_op,
    input wire logic [15:0]       o_dec_first,
    input wire logic [11:0]       o_dec_lit1,
    input wire logic [11:0]       o_dec_lit2,
    input wire logic              o_dec_nop,
    input wire logic              o_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    logic [15:0]     w_q;
    logic [PC_W-1:0] a_q;
    wire take = i_fetch_valid && !i_skip && !o_pending;
    wire mark = i_fetch_word[15:12] == `MWFD_MARK;
    wire bra  = (i_fetch_word & `MWFD_BRA_MASK) == `MWFD_BRA_VAL;
    wire jmp  = (i_fetch_word & `MWFD_JUMP_MASK) == `MWFD_JUMP_VAL;
    wire lng  = o_dec_op inside {mwfd_pkg::MWFD_OP_MOVE_FILE_LONG,
                                 mwfd_pkg::MWFD_OP_MOVE_STACK_REL_FILE_LONG};
    always_ff @(posedge i_sys_clk)
    begin
        w_q <= i_fetch_word;
        a_q <= o_fetch_addr;
    end
    property p_even;
        o_fetch_addr[0] == 1'b0;
    endproperty
    a_even: assert property (p_even)
        else $error("odd fetch address");
    property p_skip;
        i_fetch_valid && i_skip |=>
            o_fetch_addr == PC_W'(a_q + `MWFD_WORD_STEP) && !o_pending
            && !o_dec_valid;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip mishandled");
    property p_stray;
        take && mark |=> o_dec_valid && o_dec_nop && o_dec_first == w_q;
    endproperty
    a_stray: assert property (p_stray)
        else $error("stray not nop");
    property p_step;
        take && mark |=> o_fetch_addr == PC_W'(a_q + `MWFD_WORD_STEP);
    endproperty
    a_step: assert property (p_step)
        else $error("bad word step");
    property p_abs;
        o_dec_valid && o_dec_op inside {mwfd_pkg::MWFD_OP_CALL,
            mwfd_pkg::MWFD_OP_JUMP} |->
            o_fetch_addr == {o_dec_lit1, o_dec_first[7:0], 1'b0};
    endproperty
    a_abs: assert property (p_abs)
        else $error("bad absolute target");
    property p_bra;
        take && bra |=> o_dec_op == mwfd_pkg::MWFD_OP_BRANCH &&
            o_fetch_addr == PC_W'(a_q + `MWFD_WORD_STEP +
                {{(PC_W-12){w_q[10]}}, w_q[10:0], 1'b0});
    endproperty
    a_bra: assert property (p_bra)
        else $error("bad branch target");
    property p_pend;
        take && jmp |=> o_pending && !o_dec_valid;
    endproperty
    a_pend: assert property (p_pend)
        else $error("pending not set");
    property p_lit;
        o_dec_valid && !o_dec_nop && !(o_dec_op inside
            {mwfd_pkg::MWFD_OP_SINGLE, mwfd_pkg::MWFD_OP_BRANCH}) |->
            (lng ? o_dec_lit2 : o_dec_lit1) == w_q[11:0];
    endproperty
    a_lit: assert property (p_lit)
        else $error("literal lost");
    property p_req;
        !i_sys_rst |=> o_fetch_req;
    endproperty
    a_req: assert property (p_req)
        else $error("fetch request dropped");
endmodule
bind mwfd_core mwfd_core_props #(.PC_W(PC_W)) i_mwfd_core_props (.*);

// ### test/mwfd_core_tb_top.sv
// self-checking bench for the multiword fetch/decode front end
module mwfd_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed
    {
        logic [2:0]  op;
        logic [15:0] first;
        logic [11:0] lit1;
        logic [11:0] lit2;
        logic        nop;
        logic [20:0] addr;
    } mwfd_exp_t;
    logic               i_sys_clk = 1'b0;
    logic               i_sys_rst = 1'b1;
    logic [20:0]        o_fetch_addr;
    logic               o_fetch_req, i_fetch_valid, i_skip;
    logic [15:0]        i_fetch_word, o_dec_first;
    logic               o_dec_valid, o_dec_nop, o_pending;
    mwfd_pkg::mwfd_op_t o_dec_op;
    logic [11:0]        o_dec_lit1, o_dec_lit2;
    logic [11:0]        r [6];
    mwfd_exp_t          q [$];
    int                 mismatches = 0;
    int                 n_tests = 0;
    int                 li [6] = '{8, 10, 12, 13, 15, 16};
    logic [15:0]        prog [24] = '{16'hEF04, 16'hF000, 16'h0000,
        16'h0000, 16'hF123, 16'hEC07, 16'hF000, 16'hC123, 16'hF000,
        16'hEE10, 16'hF000, 16'h0063, 16'hF000, 16'hF000, 16'hEE85,
        16'hF000, 16'hF000, 16'hD001, 16'h0000, 16'h0E55, 16'hC456,
        16'hF789, 16'hEF16, 16'hF000};
    always #5 i_sys_clk = ~i_sys_clk;
    mwfd_core i_mwfd_core (.*);
    mwfd_pmem i_mwfd_pmem
    (
        .i_clk   (i_sys_clk),
        .i_addr  (o_fetch_addr),
        .i_req   (o_fetch_req),
        .o_word  (i_fetch_word),
        .o_valid (i_fetch_valid),
        .o_skip  (i_skip)
    );
    task automatic note(input logic [2:0] op, input logic [15:0] f,
                        input logic [11:0] a, b, input logic n,
                        input logic [20:0] ad);
        q.push_back('{op, f, a, b, n, ad});
    endtask
    task automatic chk(input mwfd_exp_t e);
        mwfd_exp_t g;
        g = '{o_dec_op, o_dec_first, o_dec_lit1, o_dec_lit2, o_dec_nop,
              o_fetch_addr};
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(negedge i_sys_clk)
        if (o_dec_valid === 1'b1 && q.size() > 0)
            chk(q.pop_front());
    initial
    begin
        repeat (2000) @(posedge i_sys_clk);
        mismatches++;
        print_verdict;
    end
    initial
    begin
        void'($urandom(32'h6e7d));
        foreach (r[k]) r[k] = 12'($urandom);
        foreach (li[k]) prog[li[k]] = {4'hF, r[k]};
        for (int k = 0; k < 64; k++)
            i_mwfd_pmem.mem[k] = (k < 24) ? prog[k % 24] : 16'h0000;
        for (int k = 0; k < 64; k++)
            i_mwfd_pmem.skp[k] = (k == 20);
        // second pass repeats the program after a mid-run reset
        for (int p = 0; p < 2; p++)
        begin
            i_sys_rst <= 1'b1;
            repeat (10) @(posedge i_sys_clk);
            // notes go in only once reset has silenced the outputs
            note(3'h2, 16'hEF04, 0, 0, 0, 21'h08);
            note(3'h0, 16'hF123, 0, 0, 1, 21'h0A);
            note(3'h1, 16'hEC07, 0, 0, 0, 21'h0E);
            note(3'h3, 16'hC123, r[0], 0, 0, 21'h12);
            note(3'h4, 16'hEE10, r[1], 0, 0, 21'h16);
            note(3'h5, 16'h0063, r[2], r[3], 0, 21'h1C);
            note(3'h6, 16'hEE85, r[4], r[5], 0, 21'h22);
            note(3'h7, 16'hD001, 0, 0, 0, 21'h26);
            note(3'h0, 16'h0E55, 0, 0, 0, 21'h28);
            note(3'h0, 16'hF789, 0, 0, 1, 21'h2C);
            note(3'h2, 16'hEF16, 0, 0, 0, 21'h2C);
            i_sys_rst <= 1'b0;
            for (int k = 0; k < 300 && q.size() > 0; k++)
                @(posedge i_sys_clk);
            if (q.size() > 0)
                mismatches++;
        end
        print_verdict;
    end
endmodule

// ### test/mwfd_pmem.sv
// program memory model answering fetches with random stalls
module mwfd_pmem
(
    // fetch side
    input  wire logic        i_clk,
    input  wire logic [20:0] i_addr,
    input  wire logic        i_req,
    output logic [15:0]      o_word,
    output logic             o_valid,
    output logic             o_skip
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [64];
    logic        skp [64];
    wire  [5:0]  idx = i_addr[6:1];
    initial o_valid = 1'b0;
    always @(posedge i_clk)
        o_valid <= i_req && ($urandom % 3 != 0);
    // idle word is the inverse so a stale value never passes
    assign o_word = o_valid ? mem[idx] : ~mem[idx];
    assign o_skip = o_valid && skp[idx];
endmodule

// ### verilog/mwfd_cfg.svh
// constants for the multiword fetch/decode front end
`ifndef MWFD_CFG_SVH
`define MWFD_CFG_SVH
`define MWFD_PC_W        21
`define MWFD_RESET_PC    21'h000000
`define MWFD_MARK        4'hF
`define MWFD_LIT_W       12
`define MWFD_ABS_LO_W    8
`define MWFD_BRA_W       11
`define MWFD_WORD_STEP   21'h000002
`define MWFD_ZERO_CNT    2'h0
`define MWFD_ONE_CNT     2'h1
`define MWFD_TWO_CNT     2'h2
// first-word opcode patterns: match when (word & mask) == value
`define MWFD_CALL_MASK   16'hFE00
`define MWFD_CALL_VAL    16'hEC00
`define MWFD_JUMP_MASK   16'hFF00
`define MWFD_JUMP_VAL    16'hEF00
`define MWFD_MFF_MASK    16'hF000
`define MWFD_MFF_VAL     16'hC000
`define MWFD_LIP_MASK    16'hFFC0
`define MWFD_LIP_VAL     16'hEE00
`define MWFD_MFL_MASK    16'hFFF0
`define MWFD_MFL_VAL     16'h0060
`define MWFD_MSL_MASK    16'hFF80
`define MWFD_MSL_VAL     16'hEE80
`define MWFD_BRA_MASK    16'hF800
`define MWFD_BRA_VAL     16'hD000
`endif

// ### verilog/mwfd_classify.sv
// classifies one 16-bit instruction word
`include "mwfd_cfg.svh"
module mwfd_classify
(
    // word in
    input  wire logic [15:0]        i_word,
    // class out
    output mwfd_pkg::mwfd_op_t      o_op,
    output logic [1:0]              o_extra,
    output logic                    o_marker
);
    function automatic logic hit(input logic [15:0] w,
                                 input logic [15:0] m,
                                 input logic [15:0] v);
        hit = (w & m) == v;
    endfunction

    wire is_call = hit(i_word, `MWFD_CALL_MASK, `MWFD_CALL_VAL);
    wire is_jump = hit(i_word, `MWFD_JUMP_MASK, `MWFD_JUMP_VAL);
    wire is_mff  = hit(i_word, `MWFD_MFF_MASK, `MWFD_MFF_VAL);
    wire is_lip  = hit(i_word, `MWFD_LIP_MASK, `MWFD_LIP_VAL);
    wire is_mfl  = hit(i_word, `MWFD_MFL_MASK, `MWFD_MFL_VAL);
    wire is_msl  = hit(i_word, `MWFD_MSL_MASK, `MWFD_MSL_VAL);
    wire is_bra  = hit(i_word, `MWFD_BRA_MASK, `MWFD_BRA_VAL);

    // four two-word and two three-word forms
    assign o_op = is_call ? mwfd_pkg::MWFD_OP_CALL :
                  is_jump ? mwfd_pkg::MWFD_OP_JUMP :
                  is_lip  ? mwfd_pkg::MWFD_OP_LOAD_INDIRECT_POINTER :
                  is_msl  ? mwfd_pkg::MWFD_OP_MOVE_STACK_REL_FILE_LONG :
                  is_mfl  ? mwfd_pkg::MWFD_OP_MOVE_FILE_LONG :
                  is_mff  ? mwfd_pkg::MWFD_OP_MOVE_FILE_TO_FILE :
                  is_bra  ? mwfd_pkg::MWFD_OP_BRANCH :
                            mwfd_pkg::MWFD_OP_SINGLE;
    assign o_extra = (is_mfl || is_msl) ? `MWFD_TWO_CNT :
                     (is_call || is_jump || is_lip || is_mff)
                         ? `MWFD_ONE_CNT : `MWFD_ZERO_CNT;
    assign o_marker = i_word[15:12] == `MWFD_MARK;
endmodule

// ### verilog/mwfd_core.sv
// fetch and decode front end with multi-word instruction tracking
`include "mwfd_cfg.svh"
module mwfd_core
#(
    parameter int PC_W = `MWFD_PC_W
)
(
    // clock and reset
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_sys_rst,
    // program memory fetch
    output logic [PC_W-1:0]           o_fetch_addr,
    output logic                      o_fetch_req,
    input  wire logic [15:0]          i_fetch_word,
    input  wire logic                 i_fetch_valid,
    // execute side redirects (conditional skip)
    input  wire logic                 i_skip,
    // decoded result
    output logic                      o_dec_valid,
    output mwfd_pkg::mwfd_op_t        o_dec_op,
    output logic [15:0]               o_dec_first,
    output logic [`MWFD_LIT_W-1:0]    o_dec_lit1,
    output logic [`MWFD_LIT_W-1:0]    o_dec_lit2,
    output logic                      o_dec_nop,
    output logic                      o_pending
);
    // ****************************************************
    // word classification
    // ****************************************************
    mwfd_pkg::mwfd_op_t op_w;
    logic [1:0]         extra_w;
    logic               marker_w;

    mwfd_classify u_cls
    (
        .i_word   (i_fetch_word),
        .o_op     (op_w),
        .o_extra  (extra_w),
        .o_marker (marker_w)
    );

    // ****************************************************
    // state
    // ****************************************************
    logic [PC_W-1:1]          pc_word;
    logic [1:0]               remain;
    logic                     second;
    mwfd_pkg::mwfd_op_t       held_op;
    logic [15:0]              held_first;
    logic [15:0]              held_w2;
    logic [PC_W-1:1]          next_pc_word;
    logic [1:0]               next_remain;

    wire pending = remain != `MWFD_ZERO_CNT;
    wire take    = i_fetch_valid;

    // bit zero never stored, so it always reads zero
    wire [PC_W-1:0] pc_byte = {pc_word, 1'b0};

    // sequential step: one word is two bytes
    wire [PC_W-1:0] seq_byte = PC_W'(pc_byte + `MWFD_WORD_STEP);

    // ****************************************************
    // redirect targets
    // ****************************************************
    // jump/call: word target made of the continuation literal above
    // the first word's low byte; it lands in bits 20:1
    wire [PC_W-2:0] abs_word = (PC_W-1)'({i_fetch_word[`MWFD_LIT_W-1:0],
                                          held_first[`MWFD_ABS_LO_W-1:0]});

    // branch: signed word offset, doubled to bytes
    // counted from the word after the branch, so a zero offset
    // simply falls through to the next word
    wire [`MWFD_BRA_W-1:0] bra_field = i_fetch_word[`MWFD_BRA_W-1:0];
    wire [PC_W-1:0] bra_off  = PC_W'($signed(bra_field));
    wire [PC_W-1:0] bra_byte = PC_W'(seq_byte + (bra_off << 1));

    // ****************************************************
    // decode control
    // ****************************************************
    // a word counts only when valid; idle cycles hold every state unless i_skip is high.
    // a marker word seen while nothing is pending never opens an
    // instruction, so a stray cannot swallow the words after it

    wire is_stray  = take && !pending && marker_w;
    wire is_branch = take && !pending && op_w == mwfd_pkg::MWFD_OP_BRANCH;
    wire last_cont = take && pending && remain == `MWFD_ONE_CNT;
    wire is_abs    = last_cont && (held_op == mwfd_pkg::MWFD_OP_CALL ||
                                   held_op == mwfd_pkg::MWFD_OP_JUMP);
    wire fin_multi = last_cont;
    wire fin_one   = take && !pending && extra_w == `MWFD_ZERO_CNT;

    // ****************************************************
    // counter update
    // ****************************************************
    // continuation words step the counter like any other word, so a
    // skipped first word leaves the counter on its operand word
    always_comb
    begin
        next_pc_word = pc_word;
        next_remain  = remain;
        if (i_skip)
        begin
            // a skip drops any half-taken instruction, so its
            // continuation word later decodes as a stray no-op
            next_pc_word = seq_byte[PC_W-1:1];
            next_remain  = `MWFD_ZERO_CNT;
        end
        else if (take)
        begin
            if (is_abs)
                next_pc_word = abs_word;
            else if (is_branch)
                next_pc_word = bra_byte[PC_W-1:1];
            else
                next_pc_word = seq_byte[PC_W-1:1];
            if (pending)
                next_remain = 2'(remain - `MWFD_ONE_CNT);
            else if (!marker_w)
                next_remain = extra_w;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            pc_word <= (PC_W-1)'(`MWFD_RESET_PC >> 1);
            remain  <= `MWFD_ZERO_CNT;
        end
        else
        begin
            pc_word <= next_pc_word;
            remain  <= next_remain;
        end
    end

    // ****************************************************
    // operand capture
    // ****************************************************
    // every continuation word is parked in held_w2; the last
    // word of any form is still on the bus when the result is built
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            held_op    <= mwfd_pkg::MWFD_OP_SINGLE;
            held_first <= 16'h0000;
            held_w2    <= 16'h0000;
            second     <= 1'b0;
        end
        else if (take && !i_skip && !pending && !marker_w)
        begin
            held_op    <= op_w;
            held_first <= i_fetch_word;
            second     <= 1'b0;
        end
        else if (take && !i_skip && pending)
        begin
            held_w2 <= i_fetch_word;
            second  <= 1'b1;
        end
    end

    // ****************************************************
    // registered outputs
    // ****************************************************
    wire emit = !i_skip && (fin_one || fin_multi || is_stray);
    wire [`MWFD_LIT_W-1:0] lit_now = i_fetch_word[`MWFD_LIT_W-1:0];

    // a stray marker word reports itself as a plain single-word
    // no-op, so the execute side never reads its literal as an
    // operand
    mwfd_pkg::mwfd_op_t     next_dec_op;
    logic [15:0]            next_dec_first;
    logic [`MWFD_LIT_W-1:0] next_dec_lit1;
    logic [`MWFD_LIT_W-1:0] next_dec_lit2;

    assign next_dec_op    = fin_multi ? held_op :
                            is_stray  ? mwfd_pkg::MWFD_OP_SINGLE : op_w;
    assign next_dec_first = fin_multi ? held_first : i_fetch_word;
    // a three-word form parked its middle literal; a two-word form
    // still has its only literal on the bus
    assign next_dec_lit1  = !fin_multi ? '0 :
                            second     ? held_w2[`MWFD_LIT_W-1:0] : lit_now;
    assign next_dec_lit2  = (fin_multi && second) ? lit_now : '0;

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            o_fetch_addr <= PC_W'(`MWFD_RESET_PC);
            o_fetch_req  <= 1'b0;
            o_dec_valid  <= 1'b0;
            o_dec_op     <= mwfd_pkg::MWFD_OP_SINGLE;
            o_dec_first  <= 16'h0000;
            o_dec_lit1   <= '0;
            o_dec_lit2   <= '0;
            o_dec_nop    <= 1'b0;
            o_pending    <= 1'b0;
        end
        else
        begin
            o_fetch_addr <= {next_pc_word, 1'b0};
            o_fetch_req  <= 1'b1;
            o_dec_valid  <= emit;
            o_pending    <= next_remain != `MWFD_ZERO_CNT;
            if (emit)
            begin
                o_dec_nop   <= is_stray;
                o_dec_op    <= next_dec_op;
                o_dec_first <= next_dec_first;
                o_dec_lit1  <= next_dec_lit1;
                o_dec_lit2  <= next_dec_lit2;
            end
        end
    end
endmodule

// ### verilog/mwfd_pkg.sv
// types for the multiword fetch/decode front end
package mwfd_pkg;
    typedef enum logic [2:0] {
        MWFD_OP_SINGLE,
        MWFD_OP_CALL,
        MWFD_OP_JUMP,
        MWFD_OP_MOVE_FILE_TO_FILE,
        MWFD_OP_LOAD_INDIRECT_POINTER,
        MWFD_OP_MOVE_FILE_LONG,
        MWFD_OP_MOVE_STACK_REL_FILE_LONG,
        MWFD_OP_BRANCH
    } mwfd_op_t;
endpackage
